// file: src/mqf_pkg.sv
// Shared constants and types for the multi-queue port control block
package mqf_pkg;
   localparam int DATA_W   = 36;
   localparam int DEV_W    = 3;
   localparam int QSEL_W   = 5;
   localparam int ADDR_W   = DEV_W + QSEL_W;
   localparam int NUM_Q    = 32;
   localparam int Q_DEPTH  = 4;
   // Device number sits in the top bits of a queue address
   localparam int DEV_LSB  = QSEL_W;
   localparam int DEV_MSB  = ADDR_W - 1;
   localparam int QSEL_MSB = QSEL_W - 1;

   typedef logic [DATA_W-1:0] mqf_data_t;
   typedef logic [QSEL_W-1:0] mqf_qsel_t;
   typedef logic [DEV_W-1:0]  mqf_dev_t;

   // One buffered write: target queue and its word
   typedef struct packed {
      mqf_qsel_t queue;
      mqf_data_t data;
   } mqf_wr_entry_s;

   // Read port sequencing after a queue change
   typedef enum logic [1:0] {
      MQF_RD_RUN,
      MQF_RD_OLD,
      MQF_RD_NEW
   } mqf_rd_phase_e;
endpackage

// file: src/mqf_skid_buf.sv
// Two-entry valid/ready buffer for the write data path
`timescale 1ns/1ps
module mqf_skid_buf #(
   parameter int W = 8
) (
   input  wire logic         ref_clk,   // Clock
   input  wire logic         reset_n,   // Sync reset, active low
   input  wire logic         in_valid,  // Word offered
   output logic              in_ready,  // Room for a word
   input  wire logic [W-1:0] in_data,   // Word in
   output logic              out_valid, // Word available
   input  wire logic         out_ready, // Drain side takes word
   output logic [W-1:0]      out_data   // Word out
);
   logic [W-1:0] slot [2];
   logic         rd_ptr;
   logic         wr_ptr;
   logic [1:0]   fill;
   wire          push = in_valid && in_ready;
   wire          pop  = out_valid && out_ready;

   assign in_ready  = (fill != 2'h2);
   assign out_valid = (fill != 2'h0);
   assign out_data  = slot[rd_ptr];

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
         fill   <= 2'h0;
      end else begin
         if (push) begin
            slot[wr_ptr] <= in_data;
            wr_ptr       <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         fill <= fill + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// file: src/mqf_queue_store.sv
// Storage for all queues with one push and one pop port
`timescale 1ns/1ps
module mqf_queue_store #(
   parameter int W     = 36,
   parameter int NQ    = 32,
   parameter int DEPTH = 4,
   parameter int QW    = $clog2(NQ)
) (
   input  wire logic          ref_clk,   // Clock
   input  wire logic          reset_n,   // Sync reset, active low
   input  wire logic          push,      // Store a word
   input  wire logic [QW-1:0] push_q,    // Queue to store into
   input  wire logic [W-1:0]  push_data, // Word to store
   input  wire logic          pop,       // Remove head word
   input  wire logic [QW-1:0] pop_q,     // Queue to read from
   output logic               pop_avail, // Queue pop_q holds a word
   output logic [W-1:0]       pop_data   // Head word of pop_q
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0]  mem   [NQ*DEPTH];
   logic [PW-1:0] wp    [NQ];
   logic [PW-1:0] rp    [NQ];
   logic [CW-1:0] count [NQ];

   function automatic int slot_of(input logic [QW-1:0] q,
                                  input logic [PW-1:0] p);
      slot_of = int'(q) * DEPTH + int'(p);
   endfunction

   assign pop_avail = (count[pop_q] != '0);
   assign pop_data  = mem[slot_of(pop_q, rp[pop_q])];

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         for (int i = 0; i < NQ; i++) begin
            wp[i]    <= '0;
            rp[i]    <= '0;
            count[i] <= '0;
         end
      end else begin
         if (push) begin
            mem[slot_of(push_q, wp[push_q])] <= push_data;
            wp[push_q] <= (int'(wp[push_q]) == DEPTH - 1) ? '0
                          : wp[push_q] + 1'b1;
         end
         if (pop && pop_avail) begin
            rp[pop_q] <= (int'(rp[pop_q]) == DEPTH - 1) ? '0
                         : rp[pop_q] + 1'b1;
         end
         for (int i = 0; i < NQ; i++) begin
            count[i] <= count[i]
               + CW'(push && int'(push_q) == i)
               - CW'(pop && pop_avail && int'(pop_q) == i);
         end
      end
   end
endmodule

// file: src/mqf_port_ctrl.sv
// Port control of a multi-queue FIFO with fall-through read port
`timescale 1ns/1ps
module mqf_port_ctrl #(
   parameter int DEPTH = mqf_pkg::Q_DEPTH
) (
   input  wire logic                      ref_clk,   // Clock, 200 MHz
   input  wire logic                      reset_n,   // Master reset, low
   input  wire logic                      default_config_select, // Mode
   input  wire logic                      serial_enable_in,  // Chain in
   input  wire logic                      serial_clk,        // Unused
   output logic                           serial_enable_out, // Chain out
   input  wire mqf_pkg::mqf_dev_t         device_number_pin, // Static id
   input  wire logic                      write_queue_address_strobe,
   input  wire logic [mqf_pkg::ADDR_W-1:0] write_queue_address, // Wr addr
   input  wire logic                      write_enable_n,    // Write req
   input  wire mqf_pkg::mqf_data_t        write_data,        // Write word
   output logic                           write_ready,       // Buf room
   output logic                           full_flag_n,       // Full, low
   output logic                           full_flag_oe,      // Drives FF
   input  wire logic                      read_queue_address_strobe,
   input  wire logic [mqf_pkg::ADDR_W-1:0] read_queue_address, // Rd addr
   input  wire logic                      read_enable_n,     // Read req
   input  wire logic                      output_enable_n,   // Async OE
   output mqf_pkg::mqf_data_t             data_out,          // Out word
   output logic                           data_oe,           // Drives bus
   output logic                           output_valid_n,    // Valid, low
   output logic                           output_valid_oe    // Drives OV
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   // Configuration chain
   logic cfg_default;
   logic cfg_done;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         cfg_default <= default_config_select;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         cfg_done          <= 1'b0;
         serial_enable_out <= 1'b1;
      end else if (cfg_default && !serial_enable_in) begin
         cfg_done          <= 1'b1;
         serial_enable_out <= 1'b0;
      end
   end
   // serial_clk deliberately left unread in default mode

   // Address decode
   // device match
   wire wr_sel_own = (write_queue_address[mqf_pkg::DEV_MSB:mqf_pkg::DEV_LSB]
                      == device_number_pin);
   wire rd_sel_own = (read_queue_address[mqf_pkg::DEV_MSB:mqf_pkg::DEV_LSB]
                      == device_number_pin);
   wire mqf_pkg::mqf_qsel_t wr_sel_q =
      write_queue_address[mqf_pkg::QSEL_MSB:0];
   wire mqf_pkg::mqf_qsel_t rd_sel_q =
      read_queue_address[mqf_pkg::QSEL_MSB:0];
   wire wr_sel = cfg_done && write_queue_address_strobe;
   wire rd_sel = cfg_done && read_queue_address_strobe;

   // Write port state
   mqf_pkg::mqf_qsel_t wr_q;
   logic               wr_own;
   logic [CW-1:0]      commit [mqf_pkg::NUM_Q];

   // Read port state
   mqf_pkg::mqf_rd_phase_e rd_phase;
   mqf_pkg::mqf_qsel_t     rd_q;
   mqf_pkg::mqf_qsel_t     rd_q_old;
   logic                   rd_own;
   logic                   rd_own_old;
   logic                   bus_owner;
   mqf_pkg::mqf_data_t     dout;

   // Buffer and store wiring
   mqf_pkg::mqf_wr_entry_s buf_in;
   mqf_pkg::mqf_wr_entry_s buf_out;
   logic                   buf_in_ready;
   logic                   buf_out_valid;
   logic                   pop_avail;
   mqf_pkg::mqf_data_t     pop_data;

   wire wr_take = cfg_done && !wr_sel && wr_own && !write_enable_n
                  && full_flag_n && buf_in_ready;

   assign buf_in = '{queue: wr_q, data: write_data};

   // Read side selection of which queue to pull from
   wire mqf_pkg::mqf_qsel_t pop_q = (rd_phase == mqf_pkg::MQF_RD_OLD)
                                    ? rd_q_old : rd_q;
   wire pop_own = (rd_phase == mqf_pkg::MQF_RD_OLD) ? rd_own_old : rd_own;
   // forced pulls after a change; in run, pulls on read or while output invalid
   wire want_pop = pop_own && ((rd_phase != mqf_pkg::MQF_RD_RUN)
                   || !read_enable_n || output_valid_n);
   wire rd_pop   = want_pop && pop_avail;

   // Arguments only: a continuous caller sees no hidden operands
   function automatic logic [CW-1:0] commit_after(
      input logic [CW-1:0] cnt,
      input logic          inc,
      input logic          dec);
      commit_after = cnt + CW'(inc) - CW'(dec);
   endfunction

   mqf_skid_buf #(
      .W ($bits(mqf_pkg::mqf_wr_entry_s))
   ) u_wr_buf (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .in_valid  (wr_take),
      .in_ready  (buf_in_ready),
      .in_data   (buf_in),
      .out_valid (buf_out_valid),
      .out_ready (1'b1),
      .out_data  (buf_out)
   );

   mqf_queue_store #(
      .W     (mqf_pkg::DATA_W),
      .NQ    (mqf_pkg::NUM_Q),
      .DEPTH (DEPTH),
      .QW    (mqf_pkg::QSEL_W)
   ) u_store (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .push      (buf_out_valid),
      .push_q    (buf_out.queue),
      .push_data (buf_out.data),
      .pop       (rd_pop),
      .pop_q     (pop_q),
      .pop_avail (pop_avail),
      .pop_data  (pop_data)
   );

   // Committed fill counts guard against overflow of the store
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         for (int i = 0; i < mqf_pkg::NUM_Q; i++) begin
            commit[i] <= '0;
         end
      end else begin
         for (int i = 0; i < mqf_pkg::NUM_Q; i++) begin
            commit[i] <= commit_after(commit[i],
                                      wr_take && int'(wr_q) == i,
                                      rd_pop && int'(pop_q) == i);
         end
      end
   end

   wire mqf_pkg::mqf_qsel_t next_wr_q = wr_sel ? wr_sel_q : wr_q;
   // flag follows committed fill of selected queue
   // one clock for both ports, no crossing to synchronise
   wire next_full = (commit_after(commit[next_wr_q],
                                  wr_take && wr_q == next_wr_q,
                                  rd_pop && pop_q == next_wr_q) == CNT_FULL);

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         wr_q         <= '0;
         wr_own       <= 1'b0;
         full_flag_n  <= 1'b1;
         full_flag_oe <= 1'b0;
      end else begin
         if (wr_sel) begin
            wr_q   <= wr_sel_q;
            wr_own <= wr_sel_own;
         end
         full_flag_oe <= wr_sel ? wr_sel_own : wr_own;
         full_flag_n  <= !next_full;
      end
   end

   assign write_ready = buf_in_ready;

   // Read sequencing
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         rd_phase   <= mqf_pkg::MQF_RD_RUN;
         rd_q       <= '0;
         rd_q_old   <= '0;
         rd_own     <= 1'b0;
         rd_own_old <= 1'b0;
      end else if (rd_sel) begin
         rd_phase   <= mqf_pkg::MQF_RD_OLD;
         rd_q_old   <= rd_q;
         rd_own_old <= rd_own;
         rd_q       <= rd_sel_q;
         rd_own     <= rd_sel_own;
      end else begin
         case (rd_phase)
            mqf_pkg::MQF_RD_OLD: begin
               rd_phase <= mqf_pkg::MQF_RD_NEW;
            end
            mqf_pkg::MQF_RD_NEW: begin
               rd_phase <= mqf_pkg::MQF_RD_RUN;
            end
            default: begin
               rd_phase <= mqf_pkg::MQF_RD_RUN;
            end
         endcase
      end
   end

   wire in_new = (rd_phase == mqf_pkg::MQF_RD_NEW);
   // a word was consumed and nothing follows
   wire drained = (rd_phase == mqf_pkg::MQF_RD_RUN) && !read_enable_n
                  && !output_valid_n && !pop_avail;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         dout           <= '0;
         output_valid_n <= 1'b1;
      end else if (rd_pop) begin
         dout           <= pop_data;
         output_valid_n <= 1'b0;
      end else if (in_new || drained) begin
         // old word kept but marked invalid
         output_valid_n <= 1'b1;
      end
   end

   // ownership moves with the first word of the new queue
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         bus_owner       <= 1'b0;
         output_valid_oe <= 1'b0;
      end else if (in_new) begin
         bus_owner       <= rd_own;
         output_valid_oe <= rd_own;
      end
   end

   assign data_out = dout;
   // output enable acts without a clock
   assign data_oe  = bus_owner && !output_enable_n;

   // Checks
   AST_DEFAULT_CHAIN: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (cfg_default && !serial_enable_in) |=> !serial_enable_out)
      else $error("serial enable out not low after default config");

   // Buffer drains every cycle, so its output shows the last take
   AST_NO_WRITE_ON_SELECT: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      wr_sel |=> !buf_out_valid)
      else $error("write taken on write select cycle");

   AST_FULL_BLOCKS: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      !full_flag_n |=> !buf_out_valid)
      else $error("write taken while full");

   AST_FILL_FLAG: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (wr_take && !wr_sel && !rd_pop
       && commit[wr_q] == CNT_FULL - 1'b1) |=> !full_flag_n)
      else $error("filling write did not lower full flag");

   AST_FREE_FLAG: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (!full_flag_n && rd_pop && pop_q == wr_q && !wr_sel)
      |=> full_flag_n)
      else $error("read did not raise full flag");

   AST_FF_OWNER: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (wr_sel && !wr_sel_own) |=> !full_flag_oe)
      else $error("unselected device drives full flag");

   AST_NEW_QUEUE_TWO: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (rd_sel && rd_sel_own) ##1 !rd_sel ##1 (!rd_sel && pop_avail)
      |=> !output_valid_n && dout == $past(pop_data))
      else $error("new queue word not out two cycles after select");

   AST_HOLD_IDLE: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (rd_phase == mqf_pkg::MQF_RD_RUN && read_enable_n && !output_valid_n
       && !rd_sel) |=> $stable(dout))
      else $error("output word changed while idle");

   AST_EMPTY_INVALID: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (in_new && !rd_sel && !rd_pop) |=> output_valid_n && $stable(dout))
      else $error("empty new queue not marked invalid");

   AST_OE_ASYNC: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      output_enable_n |-> !data_oe)
      else $error("data bus driven with output enable high");

   AST_OLD_WORD: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (rd_phase == mqf_pkg::MQF_RD_OLD && rd_own_old && pop_avail)
      |=> !output_valid_n && dout == $past(pop_data))
      else $error("old queue word not presented after change");

   AST_FALL_THROUGH: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (rd_phase == mqf_pkg::MQF_RD_RUN && rd_own && output_valid_n
       && pop_avail) |=> !output_valid_n && dout == $past(pop_data))
      else $error("waiting word did not fall through");

   AST_DRAIN_INVALID: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (rd_phase == mqf_pkg::MQF_RD_RUN && !read_enable_n && !output_valid_n
       && !pop_avail) |=> output_valid_n && $stable(dout))
      else $error("valid flag not raised after last word");

   AST_FF_DRIVER: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (wr_sel && wr_sel_own) |=> full_flag_oe)
      else $error("owning device does not drive full flag");

   AST_OV_HANDOVER: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      in_new |=> output_valid_oe == $past(rd_own))
      else $error("valid flag ownership not moved with new word");
endmodule

// file: verification/mqf_host_model.sv
// Host model that drives the write port of the queue device
`timescale 1ns/1ps
module mqf_host_model (
   input  wire logic                   ref_clk,      // Clock
   input  wire logic                   chain_done_n, // Chain done, low
   input  wire logic                   write_ready,  // Buffer has room
   output logic                        wr_strobe,    // Write queue select
   output logic [mqf_pkg::ADDR_W-1:0]  wr_addr,      // Write queue address
   output logic                        wr_en_n,      // Write request
   output mqf_pkg::mqf_data_t          wr_data       // Write word
);
   initial begin
      wr_strobe = 1'h0;
      wr_addr   = 8'h00;
      wr_en_n   = 1'h1;
      wr_data   = 36'h0;
   end

   task automatic sel_write(input logic [mqf_pkg::ADDR_W-1:0] a);
      wait (chain_done_n === 1'h0);
      @(posedge ref_clk);
      wr_strobe <= 1'h1;
      wr_addr   <= a;
      @(posedge ref_clk);
      wr_strobe <= 1'h0;
   endtask

   // write held until write_ready seen high, at most 50 clocks
   task automatic write_word(input mqf_pkg::mqf_data_t d);
      int n;
      wait (chain_done_n === 1'h0);
      @(posedge ref_clk);
      wr_en_n <= 1'h0;
      wr_data <= d;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (write_ready !== 1'h1 && n < 50);
      wr_en_n <= 1'h1;
      // Released bus shows no stale word
      wr_data <= ~d;
   endtask
endmodule

// file: verification/mqf_port_ctrl_test.sv
// Self-checking bench for the multi-queue port control block
`timescale 1ns/1ps
module mqf_port_ctrl_test;
   typedef struct packed {
      mqf_pkg::mqf_qsel_t q;
      mqf_pkg::mqf_data_t d;
   } mqf_row_s;
   localparam logic [2:0] DEV   = 3'h2;
   localparam logic [2:0] OTHER = 3'h5;
   localparam int         DEPTH = mqf_pkg::Q_DEPTH;
   logic                  ref_clk;
   logic                  reset_n;
   logic                  serial_clk = 1'h0;
   logic                  dflt_sel;
   logic                  rd_strobe;
   logic [7:0]            rd_addr;
   logic                  ren_n;
   logic                  oe_n;
   logic                  seo;
   logic                  wr_rdy;
   logic                  ff_n;
   logic                  ff_oe;
   mqf_pkg::mqf_data_t    dout;
   logic                  d_oe;
   logic                  ov_n;
   logic                  ov_oe;
   logic                  wr_strobe;
   logic [7:0]            wr_addr;
   logic                  wr_en_n;
   mqf_pkg::mqf_data_t    wr_data;
   mqf_pkg::mqf_data_t    prev;
   mqf_row_s              rows [4];
   int                    fail_count;
   int                    tests_run;
   int                    cycles = 0;

   mqf_port_ctrl mqf_port_ctrl_inst (
      .ref_clk                    (ref_clk),
      .reset_n                    (reset_n),
      .default_config_select      (dflt_sel),
      // first device in chain, input held low
      .serial_enable_in           (1'h0),
      .serial_clk                 (serial_clk),
      .serial_enable_out          (seo),
      .device_number_pin          (DEV),
      .write_queue_address_strobe (wr_strobe),
      .write_queue_address        (wr_addr),
      .write_enable_n             (wr_en_n),
      .write_data                 (wr_data),
      .write_ready                (wr_rdy),
      .full_flag_n                (ff_n),
      .full_flag_oe               (ff_oe),
      .read_queue_address_strobe  (rd_strobe),
      .read_queue_address         (rd_addr),
      .read_enable_n              (ren_n),
      .output_enable_n            (oe_n),
      .data_out                   (dout),
      .data_oe                    (d_oe),
      .output_valid_n             (ov_n),
      .output_valid_oe            (ov_oe)
   );

   mqf_host_model host_inst (
      .ref_clk      (ref_clk),
      .chain_done_n (seo),
      .write_ready  (wr_rdy),
      .wr_strobe    (wr_strobe),
      .wr_addr      (wr_addr),
      .wr_en_n      (wr_en_n),
      .wr_data      (wr_data)
   );

   initial begin
      ref_clk = 1'h0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // serial clock toggles, must be ignored
   always @(posedge ref_clk) begin
      serial_clk <= ~serial_clk;
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("tests run %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [35:0] e,
                      input logic [35:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic sel_read(input logic [7:0] a);
      @(posedge ref_clk);
      rd_strobe <= 1'h1;
      rd_addr   <= a;
      @(posedge ref_clk);
      rd_strobe <= 1'h0;
   endtask

   task automatic read_one();
      @(posedge ref_clk);
      ren_n <= 1'h0;
      @(posedge ref_clk);
      ren_n <= 1'h1;
   endtask

   initial begin
      dflt_sel   = 1'h1;
      rd_strobe  = 1'h0;
      rd_addr    = 8'h00;
      ren_n      = 1'h1;
      oe_n       = 1'h0;
      reset_n    = 1'h0;
      fail_count = 0;
      tests_run  = 0;
      rows[0]    = {5'h00, 36'h123456789};
      rows[1]    = {5'h1F, 36'hFFFFFFFFF};
      rows[2]    = {5'h0A, 36'h800000001};
      rows[3]    = {5'h03, 36'h5A5A5A5A5};
      repeat (10) @(posedge ref_clk);
      #1;
      chk("seo", 36'h1, 36'(seo));
      chk("ff_oe", 36'h0, 36'(ff_oe));
      chk("ov_oe", 36'h0, 36'(ov_oe));
      chk("wr_rdy", 36'h1, 36'(wr_rdy));
      chk("ff_n", 36'h1, 36'(ff_n));
      chk("ov_n", 36'h1, 36'(ov_n));
      chk("dout", 36'h0, dout);
      chk("d_oe", 36'h0, 36'(d_oe));
      @(posedge ref_clk);
      reset_n <= 1'h1;
      tick(3);
      chk("seo", 36'h0, 36'(seo));
      $display("test reset done");
      prev = 36'h0;
      foreach (rows[i]) begin
         sel_read({DEV, rows[i].q});
         tick(2);
         chk("ov_n", 36'h1, 36'(ov_n));
         chk("dout", prev, dout);
         host_inst.sel_write({DEV, rows[i].q});
         host_inst.write_word(rows[i].d);
         tick(2);
         chk("ov_n", 36'h0, 36'(ov_n));
         chk("dout", rows[i].d, dout);
         read_one();
         tick(1);
         chk("ov_n", 36'h1, 36'(ov_n));
         chk("dout", rows[i].d, dout);
         prev = rows[i].d;
      end
      $display("test rows done");
      host_inst.sel_write({DEV, 5'h05});
      tick(2);
      chk("ff_oe", 36'h1, 36'(ff_oe));
      chk("ff_n", 36'h1, 36'(ff_n));
      for (int k = 0; k < DEPTH; k++)
         host_inst.write_word(36'hA00 + 36'(k));
      tick(2);
      chk("ff_n", 36'h0, 36'(ff_n));
      host_inst.write_word(36'hBAD);
      host_inst.sel_write({OTHER, 5'h05});
      tick(2);
      chk("ff_oe", 36'h0, 36'(ff_oe));
      host_inst.sel_write({DEV, 5'h05});
      tick(2);
      chk("ff_n", 36'h0, 36'(ff_n));
      sel_read({DEV, 5'h05});
      tick(4);
      chk("ff_n", 36'h1, 36'(ff_n));
      chk("dout", 36'hA00, dout);
      for (int k = 1; k < DEPTH; k++) begin
         read_one();
         tick(1);
         chk("dout", 36'hA00 + 36'(k), dout);
      end
      read_one();
      tick(2);
      chk("ov_n", 36'h1, 36'(ov_n));
      $display("test full flag done");
      sel_read({DEV, 5'h07});
      host_inst.sel_write({DEV, 5'h07});
      for (int k = 0; k < 3; k++)
         host_inst.write_word(36'hC00 + 36'(k));
      host_inst.sel_write({DEV, 5'h08});
      host_inst.write_word(36'hD00);
      tick(3);
      chk("dout", 36'hC00, dout);
      chk("ov_n", 36'h0, 36'(ov_n));
      sel_read({DEV, 5'h08});
      tick(1);
      chk("dout", 36'hC01, dout);
      tick(1);
      chk("dout", 36'hD00, dout);
      chk("ov_n", 36'h0, 36'(ov_n));
      $display("test queue change done");
      @(posedge ref_clk);
      oe_n <= 1'h1;
      #1;
      chk("d_oe", 36'h0, 36'(d_oe));
      @(posedge ref_clk);
      oe_n <= 1'h0;
      #1;
      chk("d_oe", 36'h1, 36'(d_oe));
      sel_read({OTHER, 5'h08});
      tick(1);
      chk("ov_oe", 36'h1, 36'(ov_oe));
      tick(1);
      chk("ov_oe", 36'h0, 36'(ov_oe));
      chk("d_oe", 36'h0, 36'(d_oe));
      sel_read({DEV, 5'h07});
      tick(2);
      chk("ov_oe", 36'h1, 36'(ov_oe));
      chk("d_oe", 36'h1, 36'(d_oe));
      chk("dout", 36'hC02, dout);
      $display("test bus ownership done");
      // Second reset with default mode off: chain must stay open
      @(posedge ref_clk);
      reset_n  <= 1'h0;
      dflt_sel <= 1'h0;
      tick(3);
      chk("ov_n", 36'h1, 36'(ov_n));
      chk("dout", 36'h0, dout);
      @(posedge ref_clk);
      reset_n <= 1'h1;
      tick(3);
      chk("seo", 36'h1, 36'(seo));
      chk("d_oe", 36'h0, 36'(d_oe));
      chk("ff_oe", 36'h0, 36'(ff_oe));
      $display("test second reset done");
      print_verdict();
   end
endmodule
